// [amcc_pkg.sv]
// Purpose: Shared constants for the converter mode and calibration control block
// Assumes: 24-bit control word, MSB first on the serial port
// Notes: Field positions count from bit 0 at the LSB of the control word
package amcc_pkg;
    localparam int AMCC_WORD_BITS = 24;
    localparam int AMCC_MODE_POS = 21;
    localparam int AMCC_GAIN_POS = 18;
    localparam int AMCC_CH_POS = 17;
    localparam int AMCC_PD_POS = 16;
    localparam int AMCC_WL_POS = 15;
    localparam int AMCC_IO_POS = 14;
    localparam int AMCC_BO_POS = 13;
    localparam int AMCC_POL_POS = 12;
    localparam int AMCC_FILT_BITS = 12;
    localparam logic [23:0] AMCC_CTRL_RESET = 24'h000000;
    localparam logic [23:0] AMCC_ZS_RESET = 24'h000000;
    localparam logic [23:0] AMCC_FS_RESET = 24'h800000;
    localparam logic [2:0] AMCC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] AMCC_MODE_SELF = 3'h1;
    localparam logic [2:0] AMCC_MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] AMCC_MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] AMCC_MODE_SYS_OFFSET = 3'h4;
    localparam logic [2:0] AMCC_MODE_BACKGROUND = 3'h5;
    localparam logic [2:0] AMCC_MODE_ZS_ACCESS = 3'h6;
    localparam logic [2:0] AMCC_MODE_FS_ACCESS = 3'h7;
    localparam int AMCC_BG_SLOTS = 6;
    localparam int AMCC_CAL_CYCLES = 64;
endpackage

// [amcc_shift.sv]
// Purpose: Serial word shifter with a bit counter for one transfer
// Assumes: Data and clock strobes are synchronous one-cycle pulses
// Notes: Bits past the word length are ignored; done pulses on the last bit only
`timescale 1ns/10ps
`default_nettype none
module amcc_shift
    import amcc_pkg::*;
#(
    parameter int WIDTH = 24
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame,
    input wire logic bit_strobe,
    input wire logic bit_in,
    output logic [WIDTH-1:0] word,
    output logic done
);
    logic [5:0] count_reg;
    logic [WIDTH-1:0] word_reg;
    logic done_reg;

    // Count and shift while the frame is open; counter saturates at the width
    always_ff @(posedge clk)
    begin
        if (!rst_n || !frame)
        begin
            count_reg <= 6'h00;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (bit_strobe && count_reg < 6'(WIDTH))
            begin
                count_reg <= count_reg + 6'h01;
                done_reg <= (count_reg == 6'(WIDTH - 1));
            end
        end
    end

    // Data shift, MSB first
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            word_reg <= '0;
        else if (frame && bit_strobe && count_reg < 6'(WIDTH))
            word_reg <= {word_reg[WIDTH-2:0], bit_in};
    end

    assign word = word_reg;
    assign done = done_reg;
endmodule
`default_nettype wire

// [amcc_top.sv]
// Purpose: Mode decode, calibration sequencing and coefficient access for the converter
// Assumes: Host drives frame, bit strobes and data synchronous to clk
// Notes: Analog measurements arrive as words with a valid strobe from the modulator side
`timescale 1ns/10ps
`default_nettype none
module amcc_top
    import amcc_pkg::*;
#(
    parameter int WORD_BITS = AMCC_WORD_BITS,
    parameter int CAL_CYCLES = AMCC_CAL_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic register_select_pin,
    input wire logic write_frame,
    input wire logic read_frame,
    input wire logic serial_clk_strobe,
    input wire logic serial_data_in,
    input wire logic [23:0] meas_word,
    input wire logic meas_valid,
    output logic serial_data_out,
    output logic data_ready_n,
    output logic [2:0] operating_mode,
    output logic [7:0] gain_factor,
    output logic channel_select_bit,
    output logic power_down_bit,
    output logic word_length_bit,
    output logic comp_current_enable,
    output logic burnout_current_enable,
    output logic unipolar_select,
    output logic [11:0] filter_code,
    output logic [1:0] meas_source,
    output logic convert_active
);
    typedef enum logic [1:0] {AMCC_IDLE, AMCC_CONVERT, AMCC_CAL_ZERO, AMCC_CAL_FULL} amcc_state_e;

    logic [23:0] ctrl_reg;
    logic [23:0] zs_coef_reg [2];
    logic [23:0] fs_coef_reg [2];
    logic [23:0] data_reg;
    logic [23:0] rd_shift_reg;
    logic [5:0] rd_count_reg;
    logic rd_frame_d_reg;
    logic sdo_reg;
    logic data_ready_n_n_reg;
    logic [7:0] gain_reg;
    logic [1:0] src_reg;
    logic conv_reg;
    logic [2:0] slot_reg;
    amcc_state_e state_reg;
    logic [23:0] wr_word;
    logic wr_done;
    logic [2:0] mode;
    logic ch;
    logic pd;
    logic cal_done;
    logic coef_wr;
    logic zs_wr;
    logic fs_wr;
    logic slot_last;

    amcc_shift #(.WIDTH(WORD_BITS)) u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .frame(write_frame),
        .bit_strobe(serial_clk_strobe),
        .bit_in(serial_data_in),
        .word(wr_word),
        .done(wr_done)
    );

    assign mode = ctrl_reg[AMCC_MODE_POS +: 3];
    assign ch = ctrl_reg[AMCC_CH_POS];
    assign pd = ctrl_reg[AMCC_PD_POS];
    // Coefficient write strobe on any completed word with select high, in every mode
    assign coef_wr = wr_done && register_select_pin;
    // Split by access mode; select-high writes in any other mode are dropped
    assign zs_wr = coef_wr && (mode == AMCC_MODE_ZS_ACCESS);
    assign fs_wr = coef_wr && (mode == AMCC_MODE_FS_ACCESS);
    // Fourth conversion slot is the last one before the zero and reference slots
    assign slot_last = (slot_reg == 3'(AMCC_BG_SLOTS - 3));
    // One-step calibration finished when its full-scale slot is measured
    assign cal_done = (state_reg == AMCC_CAL_FULL) && meas_valid && (mode == AMCC_MODE_SYS_OFFSET);

    // Control word: full-word load only, one-step calibration clears mode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctrl_reg <= AMCC_CTRL_RESET;
        else if (wr_done && !register_select_pin)
            ctrl_reg <= wr_word;
        else if (cal_done)
            ctrl_reg[AMCC_MODE_POS +: 3] <= AMCC_MODE_NORMAL;
    end

    // Calibration and conversion sequencer; power-down starts nothing new
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= AMCC_IDLE;
            slot_reg <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                AMCC_IDLE:
                begin
                    slot_reg <= 3'h0;
                    if (!pd && mode == AMCC_MODE_SYS_OFFSET)
                        state_reg <= AMCC_CAL_ZERO;
                    else if (!pd && mode != AMCC_MODE_SYS_OFFSET)
                        state_reg <= AMCC_CONVERT;
                end
                AMCC_CONVERT:
                begin
                    if (pd || mode == AMCC_MODE_SYS_OFFSET)
                        state_reg <= AMCC_IDLE;
                    else if (meas_valid && mode == AMCC_MODE_BACKGROUND)
                    begin
                        // Six slots per background cycle: 4 conversions, zero, reference
                        if (slot_last)
                            state_reg <= AMCC_CAL_ZERO;
                        slot_reg <= slot_reg + 3'h1;
                    end
                end
                AMCC_CAL_ZERO:
                    if (meas_valid)
                        state_reg <= AMCC_CAL_FULL;
                AMCC_CAL_FULL:
                    if (meas_valid)
                    begin
                        slot_reg <= 3'h0;
                        state_reg <= AMCC_IDLE;
                    end
                default:
                    state_reg <= AMCC_IDLE;
            endcase
        end
    end

    // Measurement source and convert strobe for the modulator side
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            src_reg <= 2'h0;
            conv_reg <= 1'b0;
        end
        else
        begin
            conv_reg <= (state_reg != AMCC_IDLE) && !pd;
            unique case (state_reg)
                AMCC_CAL_ZERO: src_reg <= (mode == AMCC_MODE_SYS_OFFSET) ? 2'h1 : 2'h2;
                AMCC_CAL_FULL: src_reg <= 2'h3;
                default: src_reg <= {1'b0, ch};
            endcase
        end
    end

    // Coefficients per channel; host writes win over background refresh
    for (genvar c = 0; c < 2; c++)
    begin : g_coef
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                zs_coef_reg[c] <= AMCC_ZS_RESET;
                fs_coef_reg[c] <= AMCC_FS_RESET;
            end
            else if (zs_wr && ch == 1'(c))
                zs_coef_reg[c] <= wr_word;
            else if (fs_wr && ch == 1'(c))
                fs_coef_reg[c] <= wr_word;
            else if (meas_valid && ch == 1'(c) && state_reg == AMCC_CAL_ZERO)
                zs_coef_reg[c] <= meas_word;
            else if (meas_valid && ch == 1'(c) && state_reg == AMCC_CAL_FULL)
                fs_coef_reg[c] <= meas_word;
        end
    end

    // Conversion data and ready flag; ready falls on new word or one-step calibration end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            data_reg <= 24'h000000;
            data_ready_n_n_reg <= 1'b1;
        end
        else
        begin
            if (state_reg == AMCC_CONVERT && meas_valid && !pd)
            begin
                data_reg <= meas_word;
                data_ready_n_n_reg <= 1'b0;
            end
            else if (cal_done)
                data_ready_n_n_reg <= 1'b0;
            else if (read_frame && register_select_pin)
                data_ready_n_n_reg <= 1'b1;
        end
    end

    // Read shifter: load at frame start, always 24 bits; data word with 16-bit length has its low byte zeroed
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_shift_reg <= 24'h000000;
            rd_count_reg <= 6'h00;
            rd_frame_d_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end
        else
        begin
            rd_frame_d_reg <= read_frame;
            if (read_frame && !rd_frame_d_reg)
            begin
                rd_count_reg <= 6'h00;
                if (!register_select_pin)
                    rd_shift_reg <= ctrl_reg;
                else if (mode == AMCC_MODE_ZS_ACCESS)
                    rd_shift_reg <= zs_coef_reg[ch];
                else if (mode == AMCC_MODE_FS_ACCESS)
                    rd_shift_reg <= fs_coef_reg[ch];
                else if (ctrl_reg[AMCC_WL_POS])
                    rd_shift_reg <= data_reg;
                else
                    rd_shift_reg <= {data_reg[23:8], 8'h00};
            end
            else if (read_frame && serial_clk_strobe && rd_count_reg < 6'(WORD_BITS))
            begin
                sdo_reg <= rd_shift_reg[23];
                rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
                rd_count_reg <= rd_count_reg + 6'h01;
            end
            else if (!read_frame)
                sdo_reg <= 1'b0;
        end
    end

    // Gain decode, two to the field value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            gain_reg <= 8'h01;
        else
            gain_reg <= 8'h01 << ctrl_reg[AMCC_GAIN_POS +: 3];
    end

    // Configuration outputs, registered one cycle after the control word
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            operating_mode <= AMCC_MODE_NORMAL;
            channel_select_bit <= 1'b0;
            power_down_bit <= 1'b0;
            word_length_bit <= 1'b0;
            comp_current_enable <= 1'b0;
            burnout_current_enable <= 1'b0;
            unipolar_select <= 1'b0;
            filter_code <= 12'h000;
        end
        else
        begin
            operating_mode <= mode;
            channel_select_bit <= ch;
            power_down_bit <= pd;
            word_length_bit <= ctrl_reg[AMCC_WL_POS];
            comp_current_enable <= ctrl_reg[AMCC_IO_POS];
            burnout_current_enable <= ctrl_reg[AMCC_BO_POS];
            unipolar_select <= ctrl_reg[AMCC_POL_POS];
            filter_code <= ctrl_reg[AMCC_FILT_BITS-1:0];
        end
    end

    assign serial_data_out = sdo_reg;
    assign data_ready_n = data_ready_n_n_reg;
    assign gain_factor = gain_reg;
    assign meas_source = src_reg;
    assign convert_active = conv_reg;
endmodule
`default_nettype wire

// [amcc_chk.sv]
// Purpose: Port checks for the mode and calibration control
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every amcc_top instance
`timescale 1ns/10ps
`default_nettype none
module amcc_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic register_select_pin,
    input wire logic write_frame,
    input wire logic read_frame,
    input wire logic meas_valid,
    input wire logic data_ready_n,
    input wire logic [2:0] operating_mode,
    input wire logic [7:0] gain_factor,
    input wire logic channel_select_bit,
    input wire logic power_down_bit,
    input wire logic unipolar_select,
    input wire logic [1:0] meas_source,
    input wire logic convert_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Power-on field values, seen at the first edge after release
    chk_reset_vals: assert property ($rose(rst_n) |->
        gain_factor == 8'h01 && operating_mode == 3'h0 && data_ready_n &&
        !power_down_bit && !channel_select_bit && !unipolar_select)
        else $error("bad field value after reset");
    chk_gain_onehot: assert property ($onehot(gain_factor))
        else $error("gain not a power of two");
    // Fields move only after a write frame; four idle cycles cover the load latency
    chk_fields_hold: assert property (!write_frame [*4] |-> $stable(gain_factor) &&
        $stable(channel_select_bit) && $stable(unipolar_select)) else $error("field moved");
    chk_pd_idle: assert property (power_down_bit [*2] |-> !convert_active)
        else $error("converting while powered down");
    chk_cal_step: assert property (operating_mode == 3'h4 && meas_source == 2'h1 &&
        meas_valid |-> ##[1:3] meas_source == 2'h3) else $error("no reference step");
    chk_cal_done: assert property (operating_mode == 3'h4 && meas_source == 2'h3 &&
        meas_valid |-> ##[1:4] operating_mode == 3'h0 && !data_ready_n)
        else $error("offset calibration did not finish");
    chk_bg_slot: assert property (operating_mode == 3'h5 &&
        meas_source == 2'h2 && meas_valid |-> ##[1:3] meas_source == 2'h3)
        else $error("reference slot missing");
    chk_rd_clear: assert property ($rose(read_frame) && register_select_pin |->
        ##[1:3] data_ready_n) else $error("ready not cleared by read");

    // Main scenarios reached
    cov_cal: cover property (operating_mode == 3'h4 ##1 operating_mode == 3'h0);
    cov_bg: cover property (operating_mode == 3'h5 && meas_source == 2'h2 && meas_valid);
    cov_pd: cover property (power_down_bit && write_frame);
endmodule

bind amcc_top amcc_chk u_chk (.clk, .rst_n, .register_select_pin, .write_frame, .read_frame,
    .meas_valid, .data_ready_n, .operating_mode, .gain_factor, .channel_select_bit,
    .power_down_bit, .unipolar_select, .meas_source, .convert_active);
`default_nettype wire

// [amcc_host.sv]
// Purpose: Host controller model on the serial port
// Assumes: One strobe every three cycles, MSB first
// Notes: Data line toggles between bits so a stale bit never reads as valid
`timescale 1ns/10ps
`default_nettype none
module amcc_host
(
    input wire logic clk,
    input wire logic serial_data_out,
    output logic register_select_pin,
    output logic write_frame,
    output logic read_frame,
    output logic serial_clk_strobe,
    output logic serial_data_in
);
    initial
    begin
        register_select_pin = 1'b0;
        write_frame = 1'b0;
        read_frame = 1'b0;
        serial_clk_strobe = 1'b0;
        serial_data_in = 1'b0;
    end

    // One framed transfer; a count below 24 when a refusal is wanted, above 24 for an overlong frame
    task automatic xfer(input logic sel, input logic rd, input int nbits,
        input logic [23:0] wd, output logic [23:0] rw);
        logic [23:0] sh;
        sh = wd;
        rw = 24'h000000;
        @(posedge clk);
        register_select_pin <= sel;
        write_frame <= !rd;
        read_frame <= rd;
        for (int k = 0; k < nbits; k++)
        begin
            @(posedge clk);
            serial_clk_strobe <= 1'b1;
            serial_data_in <= sh[23];
            sh = {sh[22:0], 1'b1};
            @(posedge clk);
            serial_clk_strobe <= 1'b0;
            serial_data_in <= !serial_data_in;
            @(posedge clk);
            rw = {rw[22:0], serial_data_out};
        end
        @(posedge clk);
        write_frame <= 1'b0;
        read_frame <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [amcc_top_bench.sv]
// Purpose: Self-checking bench for the mode and calibration control
// Assumes: Calibration stores each measurement word as delivered
// Notes: Tests are lists of host transfers with expected values
`timescale 1ns/10ps
`default_nettype none
module amcc_top_bench;
    logic clk, rst_n, register_select_pin, write_frame, read_frame, serial_clk_strobe;
    logic serial_data_in, meas_valid, serial_data_out, data_ready_n, channel_select_bit;
    logic power_down_bit, word_length_bit, comp_current_enable, burnout_current_enable;
    logic unipolar_select, convert_active;
    logic [23:0] meas_word, got;
    logic [2:0] operating_mode;
    logic [7:0] gain_factor;
    logic [11:0] filter_code;
    logic [1:0] meas_source;
    logic [5:0] f;
    logic [23:0] st;
    int n_mismatch = 0;
    int n_checks = 0;

    amcc_top uut (.clk, .rst_n, .register_select_pin, .write_frame, .read_frame,
        .serial_clk_strobe, .serial_data_in, .meas_word, .meas_valid, .serial_data_out,
        .data_ready_n, .operating_mode, .gain_factor, .channel_select_bit, .power_down_bit,
        .word_length_bit, .comp_current_enable, .burnout_current_enable, .unipolar_select,
        .filter_code, .meas_source, .convert_active);
    amcc_host h (.clk, .serial_data_out, .register_select_pin, .write_frame, .read_frame,
        .serial_clk_strobe, .serial_data_in);

    // Mode, six flags and gain side by side
    assign st = {7'h00, operating_mode, channel_select_bit, power_down_bit, word_length_bit,
        comp_current_enable, burnout_current_enable, unipolar_select, gain_factor};

    function automatic logic [23:0] cw(input logic [2:0] m, input logic [2:0] g,
        input logic [5:0] b);
        return {m, g, b, 12'h0A5};
    endfunction

    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic meas(input logic [23:0] w);
        @(posedge clk);
        meas_word <= w;
        meas_valid <= 1'b1;
        @(posedge clk);
        meas_valid <= 1'b0;
        meas_word <= ~w;
    endtask

    // Bounded wait for a sequencer slot
    task automatic wait_src(input logic [1:0] s);
        int t;
        t = 0;
        while (meas_source !== s && t < 300)
        begin
            @(posedge clk);
            t++;
        end
        cmp("source", {22'h0, s}, {22'h0, meas_source});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is near 4000 cycles
    initial
    begin
        #400000;
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        meas_word = 24'h000000;
        meas_valid = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp("reset", 24'h000001, st);
        for (int g = 0; g < 8; g++)
        begin
            f = g[0] ? 6'h3F : 6'h00;
            h.xfer(1'b0, 1'b0, 24, cw(3'h0, g[2:0], f), got);
            cmp("state", {10'h0, f, 8'h01 << g}, st);
            h.xfer(1'b0, 1'b1, 24, 24'h000000, got);
            cmp("control", cw(3'h0, g[2:0], f), got);
            cmp("filter", 24'h0000A5, {12'h000, filter_code});
        end
        h.xfer(1'b0, 1'b0, 20, cw(3'h0, 3'h5, 6'h00), got);
        cmp("short write", {10'h0, 6'h3F, 8'h80}, st);
        h.xfer(1'b0, 1'b0, 30, cw(3'h0, 3'h3, 6'h00), got);
        cmp("long write", {10'h0, 6'h00, 8'h08}, st);
        $display("test control word done");
        for (int i = 0; i < 4; i++)
        begin
            h.xfer(1'b0, 1'b0, 24, cw({2'b11, i[1]}, 3'h0, {i[0], 1'b0, i[0], 3'h0}), got);
            h.xfer(1'b1, 1'b1, 24, 24'h000000, got);
            cmp("coef reset", i[1] ? 24'h800000 : 24'h000000, got);
            h.xfer(1'b1, 1'b0, 24, 24'hC3A510 + 24'(i), got);
            h.xfer(1'b1, 1'b0, 23, 24'h0F0F0F, got);
            h.xfer(1'b1, 1'b1, 24, 24'h000000, got);
            cmp("coef", 24'hC3A510 + 24'(i), got);
        end
        $display("test coefficients done");
        for (int w = 0; w < 2; w++)
        begin
            h.xfer(1'b0, 1'b0, 24, cw(3'h0, 3'h0, {2'b00, w[0], 3'h0}), got);
            meas(24'h5AC396);
            @(posedge clk);
            cmp("ready", 24'h0, {23'h0, data_ready_n});
            h.xfer(1'b1, 1'b1, 24, 24'h000000, got);
            cmp("data", w[0] ? 24'h5AC396 : 24'h5AC300, got);
        end
        $display("test data read done");
        h.xfer(1'b0, 1'b0, 24, cw(3'h4, 3'h0, 6'h10), got);
        repeat (20) @(posedge clk);
        cmp("halted", {20'h0, 3'h4, 1'b0}, {20'h0, operating_mode, convert_active});
        h.xfer(1'b0, 1'b0, 24, cw(3'h4, 3'h0, 6'h20), got);
        wait_src(2'h1);
        meas(24'h012345);
        wait_src(2'h3);
        meas(24'h765432);
        repeat (4) @(posedge clk);
        cmp("cal end", {20'h0, 3'h0, 1'b0}, {20'h0, operating_mode, data_ready_n});
        h.xfer(1'b0, 1'b0, 24, cw(3'h6, 3'h0, 6'h20), got);
        h.xfer(1'b1, 1'b1, 24, 24'h000000, got);
        cmp("cal zero", 24'h012345, got);
        $display("test offset calibration done");
        h.xfer(1'b0, 1'b0, 24, cw(3'h5, 3'h0, 6'h00), got);
        for (int k = 0; k < 6; k++)
        begin
            wait_src(k < 4 ? 2'h0 : 2'(k - 2));
            meas(24'h100000 + 24'(k));
        end
        h.xfer(1'b0, 1'b0, 24, cw(3'h6, 3'h0, 6'h00), got);
        h.xfer(1'b1, 1'b1, 24, 24'h000000, got);
        cmp("bg zero", 24'h100004, got);
        $display("test background done");
        give_verdict();
    end
endmodule
`default_nettype wire
